// ===== sdc_pkg.sv
/*
  Shared constants and types for the SDRAM pin command interface:
  pin widths, command codes, power states, burst length decode.
  Assumes both ends run on one clock, mclk, at 100 MHz.
*/
package sdc_pkg;
  localparam int DQ_W     = 32;
  localparam int MASK_W   = 4;
  localparam int ADDR_W   = 12;
  localparam int BA_W     = 2;
  localparam int COL_W    = 8;
  localparam int NBANK    = 4;
  localparam int AP_BIT   = 10;
  localparam int ROW_KEEP = 4;   // Low row bits held by the storage array
  localparam int RD_DLY   = 3;   // Issue edge to controller capture edge
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;

  // Order is {select_n, row_strobe_n, column_strobe_n, write_strobe_n}
  typedef enum logic [3:0] {
    CMD_LMR = 4'b0000,
    CMD_REF = 4'b0001,
    CMD_PRE = 4'b0010,
    CMD_ACT = 4'b0011,
    CMD_WR  = 4'b0100,
    CMD_RD  = 4'b0101,
    CMD_BST = 4'b0110,
    CMD_NOP = 4'b0111,
    CMD_DES = 4'b1111
  } sdc_cmd_t;

  typedef enum logic [2:0] {
    PWR_RUN  = 3'b000,
    PWR_SUSP = 3'b001,
    PWR_APD  = 3'b010,
    PWR_PPD  = 3'b011,
    PWR_SREF = 3'b100
  } sdc_pwr_t;

  // Mode op-code bits 2:0 give the burst_len code
  function automatic logic [8:0] sdc_bl_words(input logic [2:0] code);
    case (code)
      3'h1:    sdc_bl_words = 9'h002;
      3'h2:    sdc_bl_words = 9'h004;
      3'h3:    sdc_bl_words = 9'h008;
      3'h7:    sdc_bl_words = 9'h100;
      default: sdc_bl_words = 9'h001;
    endcase
  endfunction
endpackage

// ===== sdc_if.sv
/*
  Pin bundle between the memory controller and the SDRAM device.
  Assumes no end drives the data bus while the other does; an
  undriven bus reads as zero.
*/
`timescale 1ns/1ns
interface sdc_if;
  logic                         cke;
  logic                         cs_n;
  logic                         ras_n;
  logic                         cas_n;
  logic                         we_n;
  logic [sdc_pkg::BA_W-1:0]     ba;
  logic [sdc_pkg::ADDR_W-1:0]   addr;
  logic [sdc_pkg::MASK_W-1:0]   dqm;
  logic [sdc_pkg::DQ_W-1:0]     dq_ctrl_o;
  logic                         dq_ctrl_oe;
  logic [sdc_pkg::DQ_W-1:0]     dq_dev_o;
  logic [sdc_pkg::MASK_W-1:0]   dq_dev_oe;
  logic [sdc_pkg::DQ_W-1:0]     dq;

  // Wire level of the shared bus, per byte for the device side
  assign dq = dq_ctrl_oe ? dq_ctrl_o : (dq_dev_o & {{8{dq_dev_oe[3]}}, {8{dq_dev_oe[2]}},
                                                    {8{dq_dev_oe[1]}}, {8{dq_dev_oe[0]}}});

  modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
               output dq_dev_o, dq_dev_oe);
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctrl_o, dq_ctrl_oe,
                input dq);
endinterface

// ===== sdc_ctrl.sv
/*
  Controller end: turns one user request per cycle into registered
  pin levels and captures read words at the fixed read delay.
  Assumes the user issues legal command sequences and keeps
  clock gate high while read data is due.
*/
`timescale 1ns/1ns
module sdc_ctrl (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  sdc_if.ctrl                               pins,
  input  wire logic                         req_valid,
  input  wire sdc_pkg::sdc_cmd_t            req_cmd,
  input  wire logic [sdc_pkg::BA_W-1:0]     req_bank,
  input  wire logic [sdc_pkg::ADDR_W-1:0]   req_addr,
  input  wire logic [sdc_pkg::MASK_W-1:0]   req_mask,
  input  wire logic                         req_wdrive,
  input  wire logic [sdc_pkg::DQ_W-1:0]     req_wdata,
  input  wire logic                         cke_req,
  output logic [sdc_pkg::DQ_W-1:0]          rd_data,
  output logic                              rd_valid
);
  sdc_pkg::sdc_cmd_t                  cmd_r;
  logic [2:0]                         bl_code_r;
  logic [sdc_pkg::RD_DLY-1:0]         rd_sh_r;
  logic [8:0]                         rd_cnt_r;
  logic                               rd_issue;

  assign pins.cs_n  = cmd_r[3];
  assign pins.ras_n = cmd_r[2];
  assign pins.cas_n = cmd_r[1];
  assign pins.we_n  = cmd_r[0];
  assign rd_issue   = req_valid && cke_req && (req_cmd == sdc_pkg::CMD_RD);

  // Command, address and mask pins, idle as no-op, deselect out of reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_r     <= sdc_pkg::CMD_DES;
      pins.ba   <= '0;
      pins.addr <= '0;
      pins.dqm  <= '0;
    end
    else
    begin
      cmd_r     <= req_valid ? req_cmd : sdc_pkg::CMD_NOP;
      pins.ba   <= req_bank;
      pins.addr <= req_addr;
      pins.dqm  <= req_mask;
    end
  end

  // Clock gate may simply be tied high by the user
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pins.cke <= 1'b1;
    else
      pins.cke <= cke_req;
  end

  // Write data drive on the shared bus
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pins.dq_ctrl_o  <= '0;
      pins.dq_ctrl_oe <= 1'b0;
    end
    else
    begin
      pins.dq_ctrl_o  <= req_wdata;
      pins.dq_ctrl_oe <= req_valid && (req_wdrive || req_cmd == sdc_pkg::CMD_WR);
    end
  end

  // Track burst length of the last mode load sent
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      bl_code_r <= sdc_pkg::MODE_RST[2:0];
    else if (req_valid && req_cmd == sdc_pkg::CMD_LMR)
      bl_code_r <= req_addr[2:0];
  end

  // Read window: fixed delay, then one word per clock for the burst
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_sh_r  <= '0;
      rd_cnt_r <= '0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end
    else
    begin
      rd_sh_r  <= {rd_sh_r[sdc_pkg::RD_DLY-2:0], rd_issue};
      if (rd_sh_r[sdc_pkg::RD_DLY-1])
        rd_cnt_r <= sdc_pkg::sdc_bl_words(bl_code_r) - 9'h001;
      else if (rd_cnt_r != 9'h000)
        rd_cnt_r <= rd_cnt_r - 9'h001;
      rd_valid <= rd_sh_r[sdc_pkg::RD_DLY-1] || (rd_cnt_r != 9'h000);
      rd_data  <= pins.dq;
    end
  end
endmodule // sdc_ctrl

// ===== sdc_dev.sv
/*
  Device end: registered command decode, per-bank row state, burst
  engine with wrap addressing, byte-masked storage, read pipeline
  and clock-gate power states.
  Assumes the controller keeps command timing legal; storage keeps
  only the low row bits, so rows alias above that.
*/
`timescale 1ns/1ns
module sdc_dev (
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  sdc_if.dev                                pins,
  output sdc_pkg::sdc_pwr_t                 pwr_state,
  output logic [sdc_pkg::NBANK-1:0]         bank_open,
  output logic [sdc_pkg::ADDR_W-1:0]        mode_op,
  output logic                              burst_busy
);
  localparam int IDX_W = sdc_pkg::BA_W + sdc_pkg::ROW_KEEP + sdc_pkg::COL_W;

  sdc_pkg::sdc_cmd_t                  cmd;
  logic                               active_edge;
  logic                               cmd_ok;
  logic                               start;
  logic                               word_now;
  logic                               last_word;
  logic                               ap_close;
  logic [8:0]                         bl;
  logic [sdc_pkg::COL_W-1:0]          wrap_m;
  logic [sdc_pkg::COL_W-1:0]          col_now;
  logic [sdc_pkg::BA_W-1:0]           bank_now;
  logic                               wr_now;
  logic [IDX_W-1:0]                   mem_idx;
  logic [sdc_pkg::DQ_W-1:0]           mem_rd;
  logic [sdc_pkg::NBANK-1:0]          open_nxt;
  logic [sdc_pkg::ADDR_W-1:0]         row_r [sdc_pkg::NBANK];
  logic [sdc_pkg::COL_W-1:0]          base_r;
  logic [sdc_pkg::COL_W-1:0]          idx_r;
  logic [8:0]                         left_r;
  logic                               page_r;
  logic                               wr_r;
  logic                               ap_r;
  logic [sdc_pkg::BA_W-1:0]           bb_r;
  logic [sdc_pkg::DQ_W-1:0]           rd_word_r;
  logic                               rd_v_r;
  logic [sdc_pkg::MASK_W-1:0]         m1_r;

  // Strobes and select form the command on each edge
  assign cmd = sdc_pkg::sdc_cmd_t'({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n});
  // Edges in power-down are not seen past the clock gate receiver
  assign active_edge = pins.cke && (pwr_state == sdc_pkg::PWR_RUN ||
                                    pwr_state == sdc_pkg::PWR_SUSP);
  assign cmd_ok = active_edge && !pins.cs_n;
  assign start  = cmd_ok && (cmd == sdc_pkg::CMD_RD || cmd == sdc_pkg::CMD_WR);
  assign bl     = sdc_pkg::sdc_bl_words(mode_op[2:0]);
  assign wrap_m = bl[7:0] - 8'h01;

  // Current word: the command's column on start, else the wrapped count
  assign col_now   = start ? pins.addr[sdc_pkg::COL_W-1:0]
                           : (base_r & ~wrap_m) | ((base_r + idx_r) & wrap_m);
  assign bank_now  = start ? pins.ba : bb_r;
  assign wr_now    = start ? (cmd == sdc_pkg::CMD_WR) : wr_r;
  // A deselected edge still moves a running burst
  assign word_now  = active_edge && (start || (burst_busy &&
                     !(cmd_ok && cmd == sdc_pkg::CMD_BST)));
  assign last_word = start ? (bl == 9'h001) : (!page_r && left_r == 9'h001);
  assign ap_close  = word_now && last_word &&
                     (start ? pins.addr[sdc_pkg::AP_BIT] : ap_r);
  assign mem_idx   = {bank_now, row_r[bank_now][sdc_pkg::ROW_KEEP-1:0], col_now};

  // Power state from the clock gate level; exit needs only the gate high
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pwr_state <= sdc_pkg::PWR_RUN;
    else
    begin
      case (pwr_state)
        sdc_pkg::PWR_RUN, sdc_pkg::PWR_SUSP:
        begin
          if (pins.cke)
            pwr_state <= sdc_pkg::PWR_RUN;
          else if (burst_busy)
            pwr_state <= sdc_pkg::PWR_SUSP;
          else if (cmd_ok_ref(pins.cs_n, cmd))
            pwr_state <= sdc_pkg::PWR_SREF;
          else if (|bank_open)
            pwr_state <= sdc_pkg::PWR_APD;
          else
            pwr_state <= sdc_pkg::PWR_PPD;
        end
        sdc_pkg::PWR_APD, sdc_pkg::PWR_PPD, sdc_pkg::PWR_SREF:
        begin
          if (pins.cke)
            pwr_state <= sdc_pkg::PWR_RUN;
        end
        default:
          pwr_state <= sdc_pkg::PWR_RUN;
      endcase
    end
  end

  // Refresh entry is taken while the gate falls, so no active edge is needed
  function automatic logic cmd_ok_ref(input logic sel_n, input sdc_pkg::sdc_cmd_t c);
    cmd_ok_ref = !sel_n && (c == sdc_pkg::CMD_REF) &&
                 (pwr_state == sdc_pkg::PWR_RUN);
  endfunction

  // Bank open flags; a no-op or deselect leaves them alone except at the last word of an auto-precharge burst
  always_comb
  begin
    open_nxt = bank_open;
    if (ap_close)
      open_nxt[bank_now] = 1'b0;
    if (cmd_ok)
    begin
      case (cmd)
        sdc_pkg::CMD_ACT:
          open_nxt[pins.ba] = 1'b1;
        sdc_pkg::CMD_PRE:
        begin
          if (pins.addr[sdc_pkg::AP_BIT])
            open_nxt = '0;
          else
            open_nxt[pins.ba] = 1'b0;
        end
        default:
          open_nxt = open_nxt;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      bank_open <= '0;
    else
      bank_open <= open_nxt;
  end

  // Open row per bank, captured at activate
  always_ff @(posedge mclk)
  begin
    if (cmd_ok && cmd == sdc_pkg::CMD_ACT)
      row_r[pins.ba] <= pins.addr;
  end

  // Mode op-code; other mode fields are stored but only burst_len acts
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mode_op <= sdc_pkg::MODE_RST;
    else if (cmd_ok && cmd == sdc_pkg::CMD_LMR)
      mode_op <= pins.addr;
  end

  // Burst engine: holds still on a gated edge, which is clock suspend
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      burst_busy <= 1'b0;
      base_r     <= '0;
      idx_r      <= '0;
      left_r     <= '0;
      page_r     <= 1'b0;
      wr_r       <= 1'b0;
      ap_r       <= 1'b0;
      bb_r       <= '0;
    end
    else if (active_edge)
    begin
      if (start)
      begin
        burst_busy <= (bl != 9'h001);
        base_r     <= pins.addr[sdc_pkg::COL_W-1:0];
        idx_r      <= 8'h01;
        left_r     <= bl - 9'h001;
        page_r     <= bl[8];
        wr_r       <= (cmd == sdc_pkg::CMD_WR);
        ap_r       <= pins.addr[sdc_pkg::AP_BIT] && !bl[8];
        bb_r       <= pins.ba;
      end
      else if (cmd_ok && cmd == sdc_pkg::CMD_BST)
        burst_busy <= 1'b0;
      else if (burst_busy)
      begin
        idx_r <= idx_r + 8'h01;
        if (!page_r)
        begin
          left_r <= left_r - 9'h001;
          if (left_r == 9'h001)
            burst_busy <= 1'b0;
        end
      end
    end
  end

  // Storage split per byte lane so each lane has one writer
  genvar b;
  generate
    for (b = 0; b < sdc_pkg::MASK_W; b++)
    begin : g_lane
      logic [7:0] mem [2**IDX_W];
      always_ff @(posedge mclk)
      begin
        if (word_now && wr_now && !pins.dqm[b])
          mem[mem_idx] <= pins.dq[8*b +: 8];
      end
      assign mem_rd[8*b +: 8] = mem[mem_idx];
    end
  endgenerate

  // Read pipeline: fetch stage then output register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_word_r      <= '0;
      rd_v_r         <= 1'b0;
      pins.dq_dev_o  <= '0;
      pins.dq_dev_oe <= '0;
    end
    else if (active_edge)
    begin
      rd_word_r      <= mem_rd;
      rd_v_r         <= word_now && !wr_now;
      pins.dq_dev_o  <= rd_word_r;
      pins.dq_dev_oe <= {sdc_pkg::MASK_W{rd_v_r}} & ~m1_r;
    end
  end

  // Mask delay: a mask sampled at edge k floats the byte that the
  // controller captures at edge k+2, so the mask rides with its word
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      m1_r <= '0;
    else
      m1_r <= pins.dqm;
  end
endmodule // sdc_dev

// ===== sdc_chk.sv
/*
  Pin checker for the SDRAM command interface: read latency, byte masks,
  burst lengths, deselect and power-down quiet, bus ownership.
  Assumes it watches the signals of one controller and device pair.
*/
`timescale 1ns/1ns
module sdc_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [11:0] addr,
  input wire logic [3:0]  dqm,
  input wire logic        dq_ctrl_oe,
  input wire logic [3:0]  dq_dev_oe
);
  logic       cke_q_r;
  logic [3:0] rd_age_r;
  logic [2:0] bl_code_r;
  wire        run    = cke && cke_q_r;
  wire        rd_raw = !cs_n && ras_n && !cas_n && we_n;
  wire        rd     = rd_raw && run;
  wire        wr     = !cs_n && ras_n && !cas_n && !we_n;
  wire        lmr    = !cs_n && !ras_n && !cas_n && !we_n && run;

  // Gate level one edge back: the power-down exit edge takes no command
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      cke_q_r <= 1'b1;
    else
      cke_q_r <= cke;

  // Edges since the last accepted read; saturates so quiet spells stay quiet
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      rd_age_r <= 4'hf;
    else if (rd)
      rd_age_r <= 4'h0;
    else if (rd_age_r != 4'hf)
      rd_age_r <= rd_age_r + 4'h1;

  // Burst length code as last loaded into the mode register
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      bl_code_r <= 3'h0;
    else if (lmr)
      bl_code_r <= addr[2:0];

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence rd_s;
    rd && (dqm == 4'h0);
  endsequence
  sequence desel3_s;
    cs_n [*3];
  endsequence
  sequence pd_s;
    (!cke) [*3];
  endsequence

  bus_excl_a: assert property (!(dq_ctrl_oe && (dq_dev_oe != 4'h0)))
    else $error("data bus driven by both ends");
  wr_drive_a: assert property (wr |-> dq_ctrl_oe)
    else $error("write command without controller drive");
  rd_first_a: assert property (rd_s |-> ##2 (dq_dev_oe == 4'hf))
    else $error("first read word not driven two edges on");
  rd_mask_a: assert property ((dq_dev_oe != 4'h0) |-> (dq_dev_oe == ~$past(dqm, 2)))
    else $error("read byte enables do not follow the mask");
  idle_quiet_a: assert property ((rd_age_r > 4'h9) |-> (dq_dev_oe == 4'h0))
    else $error("device drives with no accepted read");
  burst_four_a: assert property (((bl_code_r == 3'h2) && rd) ##1 desel3_s |->
    ((dq_dev_oe == ~$past(dqm, 2)) [*3]) ##1 ((dq_dev_oe == 4'h0) || (rd_age_r == 4'h1)))
    else $error("four word burst has wrong length");
  burst_one_a: assert property (((bl_code_r == 3'h0) && rd) ##1 !rd |->
    ##2 (dq_dev_oe == 4'h0))
    else $error("single word burst runs on");
  pd_ignore_a: assert property (pd_s ##0 (rd_raw && (rd_age_r > 4'h9)) |->
    ##2 (dq_dev_oe == 4'h0))
    else $error("read taken while powered down");
endmodule // sdc_chk

// ===== test_sdram_pin_command_interface.sv
/*
  Self-checking bench: controller and device ends joined by the pin
  interface; random bursts with wrap, mask, deselect and power corners.
  Assumes the package, interface, both ends and the checker compile first.
*/
`timescale 1ns/1ns
module test_sdram_pin_command_interface;
  logic               mclk;
  logic               rstn;
  logic               req_valid;
  sdc_pkg::sdc_cmd_t  req_cmd;
  logic [1:0]         req_bank;
  logic [11:0]        req_addr;
  logic [3:0]         req_mask;
  logic               req_wdrive;
  logic [31:0]        req_wdata;
  logic               cke_req;
  logic [31:0]        rd_data;
  logic               rd_valid;
  sdc_pkg::sdc_pwr_t  pwr_state;
  logic [3:0]         bank_open;
  logic [11:0]        mode_op;
  logic               burst_busy;
  int                 n_errors;
  int                 num_checks;
  int                 seed;
  logic [31:0]        mem [int];
  logic [31:0]        exp_q [$];

  sdc_if pins_if ();
  sdc_ctrl sdc_ctrl_inst (.mclk(mclk), .rstn(rstn), .pins(pins_if), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_mask(req_mask),
    .req_wdrive(req_wdrive), .req_wdata(req_wdata), .cke_req(cke_req), .rd_data(rd_data),
    .rd_valid(rd_valid));
  sdc_dev sdc_dev_inst (.mclk(mclk), .rstn(rstn), .pins(pins_if), .pwr_state(pwr_state),
    .bank_open(bank_open), .mode_op(mode_op), .burst_busy(burst_busy));
  sdc_chk sdc_chk_inst (.mclk(mclk), .rstn(rstn), .cke(pins_if.cke), .cs_n(pins_if.cs_n),
    .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n), .addr(pins_if.addr),
    .dqm(pins_if.dqm), .dq_ctrl_oe(pins_if.dq_ctrl_oe), .dq_dev_oe(pins_if.dq_dev_oe));

  // Free-running 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One request per edge; strobes order is {cs, ras, cas, we}
  task automatic req(input logic [3:0] cmd, input logic [1:0] bk, input logic [11:0] ad,
                     input logic [3:0] mk, input logic wd, input logic [31:0] dat);
    @(posedge mclk);
    req_valid  <= 1'b1;
    req_cmd    <= sdc_pkg::sdc_cmd_t'(cmd);
    req_bank   <= bk;
    req_addr   <= ad;
    req_mask   <= mk;
    req_wdrive <= wd;
    req_wdata  <= dat;
  endtask

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      req_valid  <= 1'b0;
      req_wdrive <= 1'b0;
    end
  endtask

  // Whole burst; later words go out deselected so only the burst carries them
  task automatic burst(input logic rd, input logic [1:0] bk, input logic [3:0] row,
                       input logic [7:0] col, input int bl, input logic ap, input logic rm);
    logic [7:0]  c;
    logic [3:0]  mk;
    logic [31:0] d;
    int          key;
    for (int i = 0; i < bl; i++)
    begin
      c   = (col & ~8'(bl - 1)) | ((col + 8'(i)) & 8'(bl - 1));
      mk  = rm ? 4'($random(seed)) : 4'h0;
      d   = $random(seed);
      key = {bk, row, c};
      if (rd)
        exp_q.push_back(mem[key] & {{8{!mk[3]}}, {8{!mk[2]}}, {8{!mk[1]}}, {8{!mk[0]}}});
      else
        for (int b = 0; b < 4; b++)
          if (!mk[b])
            mem[key][b*8 +: 8] = d[b*8 +: 8];
      req((i == 0) ? (rd ? 4'b0101 : 4'b0100) : 4'b1111, bk, {1'b0, ap, 2'b00, col}, mk, !rd, d);
    end
  endtask

  // Read word monitor; words come in request order
  always @(posedge mclk)
  begin
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        n_errors++;
        $display("mismatch at %0t: unexpected read word", $time);
      end
      else
        chk(rd_data, exp_q.pop_front());
    end
  end

  // Watchdog well beyond the five hundred or so cycles the tests need
  initial
  begin
    #200000;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    logic [1:0] bk;
    logic [3:0] row;
    logic [7:0] col;
    logic [31:0] dw;
    seed = 71108;
    {n_errors, num_checks} = '0;
    {rstn, req_valid, req_bank, req_addr, req_mask, req_wdrive, req_wdata} = '0;
    req_cmd   = sdc_pkg::CMD_NOP;
    cke_req   = 1'b1;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    idle(2);
    chk(pwr_state, sdc_pkg::PWR_RUN);
    chk(bank_open, 4'h0);
    chk(mode_op, sdc_pkg::MODE_RST);
    // Burst lengths 1, 2, 4 and 8: full write, masked rewrite, masked read with wrap
    for (int k = 0; k < 4; k++)
    begin
      bk  = 2'($random(seed));
      row = 4'($random(seed));
      col = (k == 3) ? 8'hfd : 8'($random(seed));
      req(4'b0000, 2'b00, 12'(k), 4'h0, 1'b0, 32'h0);
      req(4'b0011, bk, {8'h00, row}, 4'h0, 1'b0, 32'h0);
      idle(3);
      chk(mode_op, 12'(k));
      chk(bank_open[bk], 1'b1);
      for (int p = 0; p < 2; p++)
      begin
        burst(1'b0, bk, row, col, 1 << k, 1'b0, p == 1);
        idle(2);
      end
      burst(1'b1, bk, row, col, 1 << k, k == 2, 1'b1);
      idle(14);
      chk(32'(exp_q.size()), 32'h0);
      chk(bank_open[bk], k != 2);
      req(4'b0010, bk, 12'h000, 4'h0, 1'b0, 32'h0);
      idle(3);
      $display("test burst code %0d done", k);
    end
    // Full page code is only loaded here and stays for the rest of the run
    req(4'b0000, 2'b00, 12'h007, 4'h0, 1'b0, 32'h0);
    idle(3);
    chk(mode_op, 12'h007);
    // Full page: four words run past the row end until a burst stop; the
    // controller keeps its window for a whole page, so the rest read as zero
    req(4'b0011, 2'd0, 12'h000, 4'h0, 1'b0, 32'h0);
    idle(2);
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 5; i++)
      begin
        col = 8'hfe + 8'(i);
        dw  = $random(seed);
        if (i == 4)
          req(4'b0110, 2'd0, 12'h000, 4'h0, 1'b0, 32'h0);
        else if (p == 0)
        begin
          mem[{2'b00, 4'h0, col}] = dw;
          req((i == 0) ? 4'b0100 : 4'b1111, 2'd0, {4'h0, 8'hfe}, 4'h0, 1'b1, dw);
        end
        else
        begin
          exp_q.push_back(mem[{2'b00, 4'h0, col}]);
          req((i == 0) ? 4'b0101 : 4'b1111, 2'd0, {4'h0, 8'hfe}, 4'h0, 1'b0, dw);
        end
      end
      idle(2);
    end
    repeat (252) exp_q.push_back(32'h0);
    idle(260);
    chk(32'(exp_q.size()), 32'h0);
    $display("test full page and burst stop done");
    // Bank steering, deselected commands, no-op, single and all precharge
    for (int b = 0; b < 4; b++)
      req(4'b0011, 2'(b), 12'h000, 4'h0, 1'b0, 32'h0);
    req(4'b0111, 2'd1, 12'h400, 4'h0, 1'b0, 32'h0);
    req(4'b1010, 2'd1, 12'h400, 4'h0, 1'b0, 32'h0);
    req(4'b1101, 2'd1, 12'h000, 4'h0, 1'b0, 32'h0);
    idle(12);
    chk(bank_open, 4'hf);
    req(4'b0010, 2'd2, 12'h000, 4'h0, 1'b0, 32'h0);
    idle(3);
    chk(bank_open, 4'hb);
    req(4'b0010, 2'd0, 12'h400, 4'h0, 1'b0, 32'h0);
    idle(3);
    chk(bank_open, 4'h0);
    $display("test bank select and precharge done");
    // Precharge power-down ignores commands; active power-down; self refresh
    cke_req <= 1'b0;
    idle(4);
    req(4'b0101, 2'd0, 12'h000, 4'h0, 1'b0, 32'h0);
    req(4'b0011, 2'd3, 12'h000, 4'h0, 1'b0, 32'h0);
    idle(3);
    chk(pwr_state, sdc_pkg::PWR_PPD);
    cke_req <= 1'b1;
    idle(4);
    chk(pwr_state, sdc_pkg::PWR_RUN);
    chk(bank_open, 4'h0);
    req(4'b0011, 2'd1, 12'h000, 4'h0, 1'b0, 32'h0);
    idle(2);
    cke_req <= 1'b0;
    idle(4);
    chk(pwr_state, sdc_pkg::PWR_APD);
    cke_req <= 1'b1;
    req(4'b0010, 2'd0, 12'h400, 4'h0, 1'b0, 32'h0);
    idle(3);
    req(4'b0001, 2'd0, 12'h000, 4'h0, 1'b0, 32'h0);
    cke_req <= 1'b0;
    idle(4);
    chk(pwr_state, sdc_pkg::PWR_SREF);
    cke_req <= 1'b1;
    idle(4);
    chk(pwr_state, sdc_pkg::PWR_RUN);
    $display("test power states done");
    end_sim();
  end
endmodule // test_sdram_pin_command_interface
